/* power_mode_fsm.v */
// power mode state machine with reset, clock gating and wishbone control registers
// Overview of operation
// - bus access only in watchdog, on, wait
// - interrupt line low outside watchdog and on
// - off left on turn-on; undervoltage blocks it
// - cold start entries; both resets low
// - reset timer expiry goes watchdog, resets high
// - ignore keepalive and standby in cold, watchdog
// - watchdog timer then on mode
// - keepalive low leaves on mode
// - shutdown bit enters wait with timer
// - keepalive ignored in wait mode
// - wait expiry: user off or memory hold
// - app reset fall clears shutdown bit
// - low power modes leave on turn-on
// - memory hold: resets low, clocks off save rights-bit processor clock
// - memory hold wake: cold start, flag set
// - held bucks stay on through warm boot
// - user off: app reset low, cpu high
// - user off processor clock gating
// - shutdown-mode bucks powered in user off
// - user off wake: warm start, bucks kept
// - warm start timer, then watchdog, flag
// - isolation switches open with app reset low
// - keepalive fall: restart bit picks cold/off
// - undervoltage without support goes off; the code goes off with support set as well
`timescale 1ns/100ps
`include "pwr_mode_map.vh"

module power_mode_fsm #(
   parameter RESET_TICKS = `RESET_TICKS,
   parameter WDOG_TICKS  = `WDOG_TICKS,
   parameter WAIT_TICKS  = `WAIT_TICKS,
   parameter BUCKS       = 4
) (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [7:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg         wb_ack_out,
   output reg         wb_err_out,
   input  wire        turn_on_in,
   input  wire        undervoltage_in,
   input  wire        watchdog_keepalive_pin_in,
   input  wire [1:0]  low_power_request_pins_in,
   input  wire        supply_loss_return_in,
   input  wire        slow_clock_in,
   input  wire        irq_req_in,
   output reg         int_out,
   output reg         app_reset_n_o_out,
   output reg         app_reset_n_oe_n_out,
   output reg         cpu_reset_n_o_out,
   output reg         cpu_reset_n_oe_n_out,
   output reg         peripheral_slow_clock_out,
   output reg         processor_slow_clock_out,
   output reg         core_isolation_switch_out,
   output reg         memory_isolation_switch_out,
   output reg  [BUCKS-1:0] buck_enable_out,
   output reg         load_defaults_out,
   output reg  [2:0]  mode_out
);

   // floored divide: the tick runs slightly fast, harmless for these coarse timers
   localparam integer DIV_LAST_INT = `SLOW_DIV - 1;
   localparam [15:0]  DIV_LAST     = DIV_LAST_INT[15:0];

   reg [2:0]  mode_reg;
   reg [2:0]  mode_next;
   reg [15:0] div_reg;
   reg        tick;
   reg [15:0] timer_reg;
   reg [15:0] timer_next;
   reg [`CTRL_WIDTH-1:0] ctrl_reg;
   reg [7:0]  buck_reg;
   reg [2:0]  flag_reg;
   reg        app_low_reg;
   reg        bus_open;
   reg        timer_done;
   reg        set_memhold;
   reg        set_warm;
   reg        set_wdi;
   reg        app_low_next;
   reg        cpu_low_next;
   reg        clr_shutdown;
   reg [BUCKS-1:0] buck_next;

   reg [`CTRL_WIDTH-1:0] ctrl_next;
   reg [2:0]  flag_next;
   reg [2:0]  flag_clr;
   reg        bus_hit;
   wire       wb_req;
   wire       wb_wr;

   assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
   assign wb_wr  = wb_req & wb_we_in & wb_sel_in[0] & bus_open;

   // slow clock tick divider
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_reg <= 16'h0000;
         tick    <= 1'b0;
      end else begin
         tick <= (div_reg == DIV_LAST);
         if (div_reg == DIV_LAST) begin
            div_reg <= 16'h0000;
         end else begin
            div_reg <= div_reg + 16'h0001;
         end
      end
   end

   // register access only while the host rails are up
   always @* begin
      bus_open = (mode_reg == `MODE_WDOG) || (mode_reg == `MODE_ON) ||
                 (mode_reg == `MODE_WAIT);
      bus_hit  = bus_open && (wb_adr_in <= `FLAG_ADDR) && (wb_adr_in[1:0] == 2'b00);
   end

   // timers count slow ticks; lengths left to the integrator
   always @* begin
      case (mode_reg)
         `MODE_COLD, `MODE_WARM: timer_done = (timer_reg >= RESET_TICKS[15:0] - 16'h0001);
         `MODE_WDOG:             timer_done = (timer_reg >= WDOG_TICKS[15:0] - 16'h0001);
         `MODE_WAIT:             timer_done = (timer_reg >= WAIT_TICKS[15:0] - 16'h0001);
         default:                timer_done = 1'b0;
      endcase
   end

   // next mode; undervoltage overrides every other exit
   always @* begin
      mode_next   = mode_reg;
      set_memhold = 1'b0;
      set_warm    = 1'b0;
      set_wdi     = 1'b0;
      if (undervoltage_in && mode_reg != `MODE_OFF) begin
         // supply-loss hold is not modelled, so loss always lands in off
         mode_next = `MODE_OFF;
      end else begin
         case (mode_reg)
            `MODE_OFF: begin
               if ((turn_on_in || supply_loss_return_in) && !undervoltage_in) begin
                  mode_next = `MODE_COLD;
               end
            end
            `MODE_COLD: begin
               // keepalive and standby pins are not looked at here
               if (tick && timer_done) begin
                  mode_next = `MODE_WDOG;
               end
            end
            `MODE_WDOG: begin
               if (ctrl_reg[`CTRL_SHUTDOWN_BIT]) begin
                  mode_next = `MODE_WAIT;
               end else if (tick && timer_done) begin
                  mode_next = `MODE_ON;
               end
            end
            `MODE_ON: begin
               if (ctrl_reg[`CTRL_SHUTDOWN_BIT]) begin
                  mode_next = `MODE_WAIT;
               end else if (!watchdog_keepalive_pin_in) begin
                  if (ctrl_reg[`CTRL_WDI_RST_BIT]) begin
                     mode_next = `MODE_COLD;
                     set_wdi   = 1'b1;
                  end else begin
                     mode_next = `MODE_OFF;
                  end
               end
            end
            `MODE_WAIT: begin
               // keepalive pin has no say in this mode
               if (tick && timer_done) begin
                  mode_next = ctrl_reg[`CTRL_WARM_EN_BIT] ? `MODE_USEROFF : `MODE_MEMHOLD;
               end
            end
            `MODE_MEMHOLD: begin
               if (turn_on_in) begin
                  mode_next   = `MODE_COLD;
                  set_memhold = 1'b1;
               end
            end
            `MODE_USEROFF: begin
               if (turn_on_in) begin
                  mode_next = `MODE_WARM;
               end
            end
            `MODE_WARM: begin
               if (tick && timer_done) begin
                  mode_next = `MODE_WDOG;
                  set_warm  = 1'b1;
               end
            end
            default: mode_next = `MODE_OFF;
         endcase
      end
   end

   // the count stops at its end in timed modes; in off, on, memory hold and user off it keeps counting and wraps
   always @* begin
      timer_next = timer_reg;
      if (mode_next != mode_reg) begin
         timer_next = 16'h0000;
      end else if (tick && !timer_done) begin
         timer_next = timer_reg + 16'h0001;
      end
   end

   always @* begin
      case (mode_next)
         `MODE_WDOG, `MODE_ON, `MODE_WAIT: begin
            app_low_next = 1'b0;
            cpu_low_next = 1'b0;
         end
         `MODE_USEROFF, `MODE_WARM: begin
            app_low_next = 1'b1;
            cpu_low_next = 1'b0;
         end
         default: begin
            app_low_next = 1'b1;
            cpu_low_next = 1'b1;
         end
      endcase
      clr_shutdown = app_low_next && !app_low_reg;
   end

   // bucks: warm boot and warm start keep the held ones until reload
   always @* begin
      case (mode_next)
         `MODE_OFF:     buck_next = {BUCKS{1'b0}};
         `MODE_MEMHOLD: buck_next = buck_reg[`BUCK_HOLD_LSB +: BUCKS];
         `MODE_USEROFF: buck_next = buck_reg[`BUCK_OFF_LSB +: BUCKS];
         `MODE_COLD:    buck_next = (mode_reg == `MODE_MEMHOLD) ?
                                    buck_reg[`BUCK_HOLD_LSB +: BUCKS] | buck_enable_out :
                                    buck_enable_out | {BUCKS{timer_done}};
         `MODE_WARM:    buck_next = buck_enable_out | {BUCKS{timer_done}};
         default:       buck_next = {BUCKS{1'b1}};
      endcase
   end

   // a hardware clear of the shutdown bit beats a same-cycle write
   always @* begin
      ctrl_next = ctrl_reg;
      if (wb_wr && wb_adr_in == `CTRL_ADDR) begin
         ctrl_next = wb_dat_in[`CTRL_WIDTH-1:0];
      end
      if (clr_shutdown) begin
         ctrl_next[`CTRL_SHUTDOWN_BIT] = 1'b0;
      end
   end

   // set wins over write-one-to-clear
   always @* begin
      flag_clr = 3'h0;
      if (wb_wr && wb_adr_in == `FLAG_ADDR) begin
         flag_clr = wb_dat_in[2:0];
      end
      flag_next = (flag_reg & ~flag_clr) | {set_wdi, set_warm, set_memhold};
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_reg    <= `MODE_OFF;
         timer_reg   <= 16'h0000;
         ctrl_reg    <= `CTRL_RESET;
         buck_reg    <= `BUCK_RESET;
         flag_reg    <= 3'h0;
         app_low_reg <= 1'b1;
      end else begin
         mode_reg    <= mode_next;
         timer_reg   <= timer_next;
         app_low_reg <= app_low_next;
         ctrl_reg    <= ctrl_next;
         if (wb_wr && wb_adr_in == `BUCK_ADDR) begin
            buck_reg <= wb_dat_in[7:0];
         end
         flag_reg    <= flag_next;
      end
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_ack_out                  <= 1'b0;
         wb_err_out                  <= 1'b0;
         wb_dat_out                  <= 32'h00000000;
         int_out                     <= 1'b0;
         app_reset_n_o_out           <= 1'b0;
         app_reset_n_oe_n_out        <= 1'b0;
         cpu_reset_n_o_out           <= 1'b0;
         cpu_reset_n_oe_n_out        <= 1'b0;
         peripheral_slow_clock_out   <= 1'b0;
         processor_slow_clock_out    <= 1'b0;
         core_isolation_switch_out   <= 1'b0;
         memory_isolation_switch_out <= 1'b0;
         buck_enable_out             <= {BUCKS{1'b0}};
         load_defaults_out           <= 1'b0;
         mode_out                    <= `MODE_OFF;
      end else begin
         // refused or unmapped accesses end with err, never hang the bus
         wb_ack_out <= wb_req && bus_hit;
         wb_err_out <= wb_req && !bus_hit;
         case (wb_adr_in)
            `CTRL_ADDR: wb_dat_out <= {25'h0000000, ctrl_reg};
            `BUCK_ADDR: wb_dat_out <= {24'h000000, buck_reg};
            `STAT_ADDR: wb_dat_out <= {29'h00000000, mode_reg};
            `FLAG_ADDR: wb_dat_out <= {29'h00000000, flag_reg};
            default:    wb_dat_out <= 32'h00000000;
         endcase
         int_out <= irq_req_in && (mode_next == `MODE_WDOG || mode_next == `MODE_ON);
         // open drain: drive low, release for high
         app_reset_n_o_out    <= 1'b0;
         app_reset_n_oe_n_out <= ~app_low_next;
         cpu_reset_n_o_out    <= 1'b0;
         cpu_reset_n_oe_n_out <= ~cpu_low_next;
         core_isolation_switch_out   <= ~app_low_next;
         memory_isolation_switch_out <= ~app_low_next;
         // clock outputs are gated copies of the crystal input
         case (mode_next)
            `MODE_OFF, `MODE_MEMHOLD: begin
               peripheral_slow_clock_out <= 1'b0;
               processor_slow_clock_out  <= slow_clock_in & ctrl_reg[`CTRL_RIGHTS_BIT];
            end
            `MODE_USEROFF: begin
               peripheral_slow_clock_out <= 1'b0;
               processor_slow_clock_out  <= slow_clock_in & ((ctrl_reg[`CTRL_CPU_CLK_BIT] &
                                            ctrl_reg[`CTRL_OFF_CLK_BIT]) | ctrl_reg[`CTRL_RIGHTS_BIT]);
            end
            default: begin
               peripheral_slow_clock_out <= slow_clock_in;
               processor_slow_clock_out  <= slow_clock_in & (ctrl_reg[`CTRL_CPU_CLK_BIT] | ctrl_reg[`CTRL_RIGHTS_BIT]);
            end
         endcase
         buck_enable_out   <= buck_next;
         load_defaults_out <= (mode_next != mode_reg) &&
                              (mode_next == `MODE_COLD || mode_next == `MODE_WARM);
         mode_out          <= mode_next;
      end
   end

endmodule

/* pwr_mode_map.vh */
// register map, field positions, reset values and state codes of the power mode sequencer
`ifndef PWR_MODE_MAP_VH
`define PWR_MODE_MAP_VH

// register byte addresses
`define CTRL_ADDR          8'h00
`define BUCK_ADDR          8'h04
`define STAT_ADDR          8'h08
`define FLAG_ADDR          8'h0C

// control register fields
`define CTRL_SHUTDOWN_BIT  0
`define CTRL_WARM_EN_BIT   1
`define CTRL_RIGHTS_BIT    2
`define CTRL_CPU_CLK_BIT   3
`define CTRL_OFF_CLK_BIT   4
`define CTRL_WDI_RST_BIT   5
`define CTRL_LOSS_EN_BIT   6
`define CTRL_WIDTH         7
`define CTRL_RESET         7'h08

// buck register: hold mode bits in [3:0], shutdown mode bits in [7:4]
`define BUCK_HOLD_LSB      0
`define BUCK_OFF_LSB       4
`define BUCK_RESET         8'h00

// flag register fields, write one to clear
`define FLAG_MEMHOLD_BIT   0
`define FLAG_WARM_BIT      1
`define FLAG_WDI_RST_BIT   2

// mode codes
`define MODE_OFF           3'h0
`define MODE_COLD          3'h1
`define MODE_WDOG          3'h2
`define MODE_ON            3'h3
`define MODE_WAIT          3'h4
`define MODE_MEMHOLD       3'h5
`define MODE_USEROFF       3'h6
`define MODE_WARM          3'h7

// timer lengths in slow clock ticks
`define RESET_TICKS        16
`define WDOG_TICKS         32
`define WAIT_TICKS         64

// slow tick divider: 10 MHz / 32.768 kHz rounded down
`define CLK_HZ             10000000
`define SLOW_HZ            32768
`define SLOW_DIV           (`CLK_HZ / `SLOW_HZ)

`endif

/* power_mode_fsm_assertions.sv */
// port checker for the power mode sequencer
`timescale 1ns/100ps
module power_mode_fsm_assertions (
   input logic       clk_in,
   input logic       nrst_in,
   input logic       wb_cyc_in,
   input logic       wb_stb_in,
   input logic       wb_ack_out,
   input logic       wb_err_out,
   input logic       undervoltage_in,
   input logic       watchdog_keepalive_pin_in,
   input logic       int_out,
   input logic       app_reset_n_oe_n_out,
   input logic       cpu_reset_n_oe_n_out,
   input logic       peripheral_slow_clock_out,
   input logic       core_isolation_switch_out,
   input logic       memory_isolation_switch_out,
   input logic       load_defaults_out,
   input logic [2:0] mode_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire live = mode_out == 3'h2 || mode_out == 3'h3;
   wire take = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
   wire app = app_reset_n_oe_n_out;
   wire cpu = cpu_reset_n_oe_n_out;
   bus_refuse_a: assert property (take && !live && mode_out != 3'h4 |=> wb_err_out && !wb_ack_out)
      else $error("bus access not refused");
   irq_gate_a: assert property (!live |-> !int_out) else $error("interrupt line not held low");
   cold_hold_a: assert property (mode_out == 3'h1 |-> !app && !cpu) else $error("resets released in cold");
   cold_exit_a: assert property (mode_out == 3'h1 && !undervoltage_in |=> mode_out inside {3'h1, 3'h2})
      else $error("cold start left to wrong mode");
   live_reset_a: assert property (live |-> app && cpu) else $error("resets low while live");
   on_drop_a: assert property (mode_out == 3'h3 && !watchdog_keepalive_pin_in |=> mode_out inside {3'h0, 3'h1})
      else $error("keepalive loss not acted on");
   wait_keep_a: assert property (mode_out == 3'h4 && !undervoltage_in |=> mode_out inside {3'h4, 3'h5, 3'h6})
      else $error("wait mode left wrongly");
   memhold_out_a: assert property (mode_out == 3'h5 |-> !app && !cpu && !peripheral_slow_clock_out)
      else $error("memory hold outputs wrong");
   useroff_out_a: assert property (mode_out == 3'h6 |-> !app && cpu && !peripheral_slow_clock_out)
      else $error("user off outputs wrong");
   isolate_a: assert property (!app |-> !core_isolation_switch_out && !memory_isolation_switch_out)
      else $error("isolation switch closed with app reset low");
   uv_off_a: assert property (undervoltage_in && mode_out != 3'h0 |=> mode_out == 3'h0)
      else $error("undervoltage did not force off");
   defaults_a: assert property ($changed(mode_out) && mode_out inside {3'h1, 3'h7} |-> load_defaults_out)
      else $error("defaults not loaded on start");
   cover property (mode_out == 3'h6);
   cover property (mode_out == 3'h5);
   cover property (take && mode_out == 3'h0);
endmodule

/* pwr_host_model.sv */
// host processor model driving the keepalive pin
`timescale 1ns/100ps
module pwr_host_model (
   input  logic clk_in,
   input  logic cpu_reset_n_in,
   input  logic hang_in,
   output logic watchdog_keepalive_pin_out = 1'b0
);
   // a hung processor lets the pin fall; hang and undervoltage are the faults the bench commands
   always @(posedge clk_in) begin
      watchdog_keepalive_pin_out <= cpu_reset_n_in && !hang_in;
   end
endmodule

/* tb.sv */
// self-checking bench for the power mode sequencer
`timescale 1ns/100ps
`include "pwr_mode_map.vh"
module tb;
   logic        clk_in = 0, nrst_in = 0, slow = 0, cyc = 0, stb = 0, we = 0;
   logic        ton = 0, uv = 0, irq = 0, hang = 0, slr = 0, seen;
   logic [1:0]  lpr = 2'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd, r;
   wire  [31:0] rdat;
   wire         ack, err, intr, app_o, app_oe, cpu_o, cpu_oe, pclk, mclk, ciso, miso, ld, watchdog_keepalive_pin;
   wire  [3:0]  buck;
   wire  [2:0]  mode;
   wire         cpu_pin = cpu_oe ? 1'b1 : cpu_o;
   int          fails = 0, check_count = 0, sdiv = 0;
   always #50 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (sdiv == 151) begin
         sdiv <= 0;
         slow <= ~slow;
      end else begin
         sdiv <= sdiv + 1;
      end
   end
   // short timers keep the run brief
   power_mode_fsm #(.RESET_TICKS(2), .WDOG_TICKS(2), .WAIT_TICKS(2)) DUT (
      .clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .wb_err_out(err), .turn_on_in(ton), .undervoltage_in(uv), .watchdog_keepalive_pin_in(watchdog_keepalive_pin),
      .low_power_request_pins_in(lpr), .supply_loss_return_in(slr), .slow_clock_in(slow),
      .irq_req_in(irq), .int_out(intr), .app_reset_n_o_out(app_o), .app_reset_n_oe_n_out(app_oe),
      .cpu_reset_n_o_out(cpu_o), .cpu_reset_n_oe_n_out(cpu_oe), .peripheral_slow_clock_out(pclk),
      .processor_slow_clock_out(mclk), .core_isolation_switch_out(ciso),
      .memory_isolation_switch_out(miso), .buck_enable_out(buck), .load_defaults_out(ld), .mode_out(mode));
   pwr_host_model host (.clk_in(clk_in), .cpu_reset_n_in(cpu_pin), .hang_in(hang), .watchdog_keepalive_pin_out(watchdog_keepalive_pin));
   function automatic logic mcu_clk_exp(input logic rights, input logic cpu_en, input logic off_clk);
      return rights | (cpu_en & off_clk);
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic exp_err);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_in);
      while (ack !== 1'b1 && err !== 1'b1) begin
         @(posedge clk_in);
      end
      rd = rdat;
      check(err, exp_err);
      cyc <= 0;
      stb <= 0;
      @(posedge clk_in);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      check(mode, m);
   endtask
   task automatic watch_clk(input logic exp);
      seen = 0;
      repeat (400) @(posedge clk_in) if (mclk === 1'b1) seen = 1;
      check(seen, exp);
   endtask
   initial begin
      #5000000;
      fails++;
      tally_and_finish;
   end
   initial begin
      r = $urandom(55);
      repeat (16) @(posedge clk_in);
      nrst_in <= 1;
      @(posedge clk_in);
      bus(0, `CTRL_ADDR, 32'h0, 1);
      uv <= 1;
      ton <= 1;
      repeat (20) @(posedge clk_in);
      check(mode, `MODE_OFF);
      uv <= 0;
      wait_mode(`MODE_COLD);
      ton <= 0;
      check({app_oe, cpu_oe}, 2'b00);
      wait_mode(`MODE_WDOG);
      check({app_oe, cpu_oe}, 2'b11);
      wait_mode(`MODE_ON);
      bus(0, `CTRL_ADDR, 32'h0, 0);
      check(rd[6:0], `CTRL_RESET);
      irq <= 1;
      repeat (3) @(posedge clk_in);
      check(intr, 1'b1);
      repeat (4) begin
         r = $urandom;
         lpr <= r[9:8];
         bus(1, `BUCK_ADDR, r, 0);
         bus(0, `BUCK_ADDR, 32'h0, 0);
         check(rd[7:0], r[7:0]);
         bus(0, r[23:16] | 8'h10, 32'h0, 1);
      end
      bus(1, `CTRL_ADDR, 32'h1B, 0);
      wait_mode(`MODE_WAIT);
      bus(0, `STAT_ADDR, 32'h0, 0);
      check(rd[2:0], `MODE_WAIT);
      hang <= 1;
      wait_mode(`MODE_USEROFF);
      check(intr, 1'b0);
      check(buck, r[7:4]);
      watch_clk(mcu_clk_exp(0, 1, 1));
      hang <= 0;
      ton <= 1;
      wait_mode(`MODE_WARM);
      check(buck, r[7:4]);
      ton <= 0;
      check({app_oe, cpu_oe}, 2'b01);
      wait_mode(`MODE_WDOG);
      bus(0, `FLAG_ADDR, 32'h0, 0);
      check(rd[`FLAG_WARM_BIT], 1'b1);
      bus(0, `CTRL_ADDR, 32'h0, 0);
      check(rd[`CTRL_SHUTDOWN_BIT], 1'b0);
      bus(1, `FLAG_ADDR, 32'h07, 0);
      wait_mode(`MODE_ON);
      bus(1, `CTRL_ADDR, 32'h09, 0);
      wait_mode(`MODE_MEMHOLD);
      watch_clk(mcu_clk_exp(0, 1, 0));
      ton <= 1;
      wait_mode(`MODE_COLD);
      check(buck, r[3:0]);
      ton <= 0;
      wait_mode(`MODE_WDOG);
      bus(0, `FLAG_ADDR, 32'h0, 0);
      check(rd[`FLAG_MEMHOLD_BIT], 1'b1);
      wait_mode(`MODE_ON);
      bus(1, `CTRL_ADDR, 32'h28, 0);
      hang <= 1;
      wait_mode(`MODE_COLD);
      hang <= 0;
      wait_mode(`MODE_WDOG);
      bus(0, `FLAG_ADDR, 32'h0, 0);
      check(rd[`FLAG_WDI_RST_BIT], 1'b1);
      wait_mode(`MODE_ON);
      bus(1, `CTRL_ADDR, 32'h0C, 0);
      hang <= 1;
      wait_mode(`MODE_OFF);
      hang <= 0;
      watch_clk(mcu_clk_exp(1, 1, 0));
      slr <= 1;
      wait_mode(`MODE_COLD);
      slr <= 0;
      wait_mode(`MODE_WDOG);
      uv <= 1;
      wait_mode(`MODE_OFF);
      uv <= 0;
      tally_and_finish;
   end
endmodule
bind power_mode_fsm power_mode_fsm_assertions chk (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out), .undervoltage_in(undervoltage_in),
   .watchdog_keepalive_pin_in(watchdog_keepalive_pin_in), .int_out(int_out),
   .app_reset_n_oe_n_out(app_reset_n_oe_n_out), .cpu_reset_n_oe_n_out(cpu_reset_n_oe_n_out),
   .peripheral_slow_clock_out(peripheral_slow_clock_out), .core_isolation_switch_out(core_isolation_switch_out),
   .memory_isolation_switch_out(memory_isolation_switch_out), .load_defaults_out(load_defaults_out),
   .mode_out(mode_out));
